// File: core/scg_params.svh
`ifndef SCG_PARAMS_SVH
`define SCG_PARAMS_SVH
`define SCG_BASE_ADDR    32'h400FE000
`define SCG_OFF_SLEEP    12'h114
`define SCG_OFF_IRQ_STAT 12'h200
`define SCG_OFF_IRQ_MASK 12'h204
`define SCG_RESET_VALUE  32'h00000000
`define SCG_WRITE_MASK   32'h070F1013
`define SCG_NUM_UNITS    11
`define SCG_IRQ_BITS     2
`define SCG_IRQ_FAULT    0
`define SCG_IRQ_UNMAPPED 1
`endif

// File: core/scg_pkg.sv
package scg_pkg;
	// peripheral access as seen by the gate block
	typedef struct packed {
		logic        req;
		logic [3:0]  unit;
	} scg_periph_req_s;

	typedef enum logic [2:0] {
		SCG_IDLE  = 3'b001,
		SCG_READ  = 3'b010,
		SCG_WRITE = 3'b100
	} scg_bus_e;
endpackage : scg_pkg

// File: core/scg_sleep_gate.sv
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "scg_params.svh"

// sleep-mode clock enable register with gated unit clocks
module scg_sleep_gate (
	input  wire logic                         ref_clk,
	input  wire logic                         arst_n,
	input  wire logic [11:0]                  avs_address,
	input  wire logic                         avs_read,
	input  wire logic                         avs_write,
	input  wire logic [31:0]                  avs_writedata,
	input  wire logic [3:0]                   avs_byteenable,
	output logic      [31:0]                  avs_readdata,
	output logic      [1:0]                   avs_response,
	output logic                              avs_waitrequest,
	input  wire logic                         sleep_active,
	input  wire logic                         auto_clock_gating_enable,
	input  wire logic [`SCG_NUM_UNITS-1:0]    run_gate_enable,
	input  wire scg_pkg::scg_periph_req_s     periph_req,
	output logic                              periph_fault,
	output logic      [`SCG_NUM_UNITS-1:0]    unit_clk_en,
	output logic      [`SCG_NUM_UNITS-1:0]    unit_clk,
	output logic                              irq
);

	logic [31:0]                   sleep_clock_gate_ctrl_one;
	logic [`SCG_IRQ_BITS-1:0]      irq_stat;
	logic [`SCG_IRQ_BITS-1:0]      irq_mask;
	scg_pkg::scg_bus_e             bus_state;
	logic                          sleep_s1;
	logic                          sleep_s2;
	logic                          acg_s1;
	logic                          acg_s2;
	logic [`SCG_NUM_UNITS-1:0]     sleep_en;
	logic [`SCG_NUM_UNITS-1:0]     next_en;
	logic [`SCG_NUM_UNITS-1:0]     en_latch;
	logic [31:0]                   wr_bits;
	logic                          hit_sleep;
	logic                          hit_stat;
	logic                          hit_mask;
	logic                          unmapped;
	logic                          req;
	logic                          fault_evt;
	logic                          unmap_evt;

	// sleep and gating mode come from the power controller, async;
	// two stages keep a metastable first stage away from the mux,
	// at the cost of a two-edge lag before gating follows the mode
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sleep_s1 <= 1'b0;
			sleep_s2 <= 1'b0;
			acg_s1   <= 1'b0;
			acg_s2   <= 1'b0;
		end else begin
			sleep_s1 <= sleep_active;
			sleep_s2 <= sleep_s1;
			acg_s1   <= auto_clock_gating_enable;
			acg_s2   <= acg_s1;
		end
	end

	// the second stage only ever follows the first, one edge late
	a_sleep_sync:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		sleep_s2 == $past(sleep_s1))
		else $error("sleep synchroniser skipped a stage");
	a_acg_sync:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		acg_s2 == $past(acg_s1))
		else $error("gating synchroniser skipped a stage");

	// bus decode on the byte offset; anything not listed here is
	// refused with a decode error rather than silently aliased
	assign req       = avs_read | avs_write;
	assign hit_sleep = (avs_address == `SCG_OFF_SLEEP);
	assign hit_stat  = (avs_address == `SCG_OFF_IRQ_STAT);
	assign hit_mask  = (avs_address == `SCG_OFF_IRQ_MASK);
	assign unmapped  = req & ~(hit_sleep | hit_stat | hit_mask);
	// one wait cycle: answer on the second edge of a request
	assign avs_waitrequest = req & (bus_state == scg_pkg::SCG_IDLE);

	// byte lanes merge with the stored value so a narrow write
	// leaves the other lanes alone
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wr_bits[i*8 +: 8] = avs_byteenable[i] ?
				avs_writedata[i*8 +: 8] :
				sleep_clock_gate_ctrl_one[i*8 +: 8];
		end
	end

	// bus phase tracker: one-hot, every request spends one cycle in
	// idle (waitrequest high) and one in read or write (the answer)
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_state <= scg_pkg::SCG_IDLE;
		end else begin
			case (bus_state)
				scg_pkg::SCG_IDLE: begin
					if (avs_read)
						bus_state <= scg_pkg::SCG_READ;
					else if (avs_write)
						bus_state <= scg_pkg::SCG_WRITE;
				end
				default: bus_state <= scg_pkg::SCG_IDLE;
			endcase
		end
	end

	// a request always sees exactly one wait state, then an answer
	a_wait_first:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(req && bus_state == scg_pkg::SCG_IDLE) |-> avs_waitrequest)
		else $error("request answered without a wait state");
	a_phase_back:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		bus_state != scg_pkg::SCG_IDLE |=> bus_state == scg_pkg::SCG_IDLE)
		else $error("bus phase stuck after the answer");
	a_bus_onehot:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		$onehot(bus_state))
		else $error("bus phase not one-hot");

	// the gate register; reserved bits never store, so read zero
	// the write lands on the answering edge, never in the wait cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sleep_clock_gate_ctrl_one <= `SCG_RESET_VALUE;
		end else if (bus_state == scg_pkg::SCG_WRITE && avs_write
			&& hit_sleep) begin
			sleep_clock_gate_ctrl_one <= wr_bits & `SCG_WRITE_MASK;
		end
	end

	// reset clears everything; the register moves only when written
	a_reset_clear:
		assert property (@(posedge ref_clk)
		!arst_n |-> (sleep_clock_gate_ctrl_one == `SCG_RESET_VALUE
		&& unit_clk_en == '0 && irq_stat == '0))
		else $error("state not cleared in reset");
	a_hold_value:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		!(bus_state == scg_pkg::SCG_WRITE && avs_write && hit_sleep)
		|=> $stable(sleep_clock_gate_ctrl_one))
		else $error("gate register changed without a write");
	a_lane_skip:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(bus_state == scg_pkg::SCG_WRITE && avs_write && hit_sleep
		&& avs_byteenable == 4'h0) |=> $stable(sleep_clock_gate_ctrl_one))
		else $error("write with no lanes changed the register");

	// read data registered, valid through the answer cycle
	// captured in the wait cycle so the answer edge sees settled data
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= 32'h00000000;
			avs_response <= 2'h0;
		end else if (bus_state == scg_pkg::SCG_IDLE && req) begin
			avs_response <= unmapped ? 2'h3 : 2'h0;
			if (hit_sleep)
				avs_readdata <= sleep_clock_gate_ctrl_one;
			else if (hit_stat)
				avs_readdata <= {30'h0, irq_stat};
			else if (hit_mask)
				avs_readdata <= {30'h0, irq_mask};
			else
				avs_readdata <= 32'h00000000;
		end
	end

	// read data and response stand from the answer to the next request
	a_read_value:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(bus_state == scg_pkg::SCG_READ && avs_read && hit_sleep)
		|-> avs_readdata == sleep_clock_gate_ctrl_one)
		else $error("read data not the gate register");
	a_unmapped_err:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(!avs_waitrequest && unmapped) |-> avs_response == 2'h3)
		else $error("unmapped access not refused");
	a_mapped_okay:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(!avs_waitrequest && req && !unmapped) |-> avs_response == 2'h0)
		else $error("mapped access refused");
	a_data_stands:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		!(bus_state == scg_pkg::SCG_IDLE && req)
		|=> $stable(avs_readdata) && $stable(avs_response))
		else $error("read data moved between requests");

	// unit order: async_serial_zero_clock_gate, async_serial_one_clock_gate, ssi, twi, tmr0..3, cmp0..2
	assign sleep_en = {
		sleep_clock_gate_ctrl_one[26:24],
		sleep_clock_gate_ctrl_one[19:16],
		sleep_clock_gate_ctrl_one[12],
		sleep_clock_gate_ctrl_one[4],
		sleep_clock_gate_ctrl_one[1:0]
	};

	// each unit enable sits at its own register bit, nothing shared
	a_counter_map:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		sleep_en[7:4] == sleep_clock_gate_ctrl_one[19:16])
		else $error("counter enables misplaced");
	a_serial_map:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		sleep_en[2] == sleep_clock_gate_ctrl_one[4] &&
		sleep_en[1:0] == sleep_clock_gate_ctrl_one[1:0])
		else $error("serial port enables misplaced");

	// sleep set only counts when automatic gating is on
	// otherwise the run enables stay in force, asleep or not
	always_comb begin
		if (sleep_s2 && acg_s2)
			next_en = sleep_en;
		else
			next_en = run_gate_enable;
	end

	// enables registered so downstream sees clean levels
	// one more edge of lag, but no decode glitch reaches the gates
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			unit_clk_en <= '0;
		else
			unit_clk_en <= next_en;
	end

	// latch while clock low: enable changes never clip a pulse
	// the enable may only move at a rising edge, so the latch is
	// closed for the whole high phase the gated clock can show
	always_latch begin
		if (!ref_clk)
			en_latch = unit_clk_en;
	end
	assign unit_clk = en_latch & {`SCG_NUM_UNITS{ref_clk}};

	// at each rising edge the latch holds the enable set up before
	// it, so a pulse is either whole or absent
	a_latch_steady:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		en_latch == unit_clk_en)
		else $error("clock gate latch out of step");

	// an access to an unclocked unit faults
	// unit numbers past the last unit have no clock and never fault
	assign periph_fault = periph_req.req &&
		(periph_req.unit < 4'(`SCG_NUM_UNITS)) &&
		!unit_clk_en[periph_req.unit];
	assign fault_evt = periph_fault;
	assign unmap_evt = unmapped && bus_state == scg_pkg::SCG_IDLE;

	// fault exactly when the addressed unit is gated, for every unit
	a_no_false_fault:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(periph_req.req && periph_req.unit < 4'(`SCG_NUM_UNITS)
		&& unit_clk_en[periph_req.unit]) |-> !periph_fault)
		else $error("fault on a clocked unit");
	a_fault_any:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(periph_req.req && periph_req.unit < 4'(`SCG_NUM_UNITS)
		&& !unit_clk_en[periph_req.unit]) |-> periph_fault)
		else $error("no fault on a gated unit");
	a_no_req_quiet:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		!periph_req.req |-> !periph_fault)
		else $error("fault without an access");

	// sticky events, set wins over write-one-to-clear
	// so an event in the clearing cycle is never lost
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat <= '0;
		end else begin
			if (bus_state == scg_pkg::SCG_WRITE && avs_write && hit_stat
				&& avs_byteenable[0])
				irq_stat <= irq_stat & ~avs_writedata[1:0]
					| {unmap_evt, fault_evt};
			else
				irq_stat <= irq_stat | {unmap_evt, fault_evt};
		end
	end

	// a status bit stays until software writes a one to it
	a_unmap_sticky:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		unmap_evt |=> irq_stat[1])
		else $error("unmapped event lost");
	a_stat_clear:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(bus_state == scg_pkg::SCG_WRITE && avs_write && hit_stat
		&& avs_byteenable[0] && avs_writedata[0] && !fault_evt)
		|=> !irq_stat[0])
		else $error("fault status not cleared");

	// mask register, same layout as the status register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			irq_mask <= '0;
		else if (bus_state == scg_pkg::SCG_WRITE && avs_write && hit_mask
			&& avs_byteenable[0])
			irq_mask <= avs_writedata[1:0];
	end

	a_mask_hold:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		!(bus_state == scg_pkg::SCG_WRITE && avs_write && hit_mask
		&& avs_byteenable[0]) |=> $stable(irq_mask))
		else $error("mask changed without a write");

	// level output: it drops as soon as the status bit is cleared
	assign irq = |(irq_stat & irq_mask);
	a_irq_masked:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		irq_mask == '0 |-> !irq)
		else $error("masked event raised the interrupt");

	// reserved bits can never hold a one, whatever was written
	a_reserved_zero:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(sleep_clock_gate_ctrl_one & ~`SCG_WRITE_MASK) == 32'h0)
		else $error("reserved bit set");
	a_write_lands:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(bus_state == scg_pkg::SCG_WRITE && avs_write && hit_sleep
		&& avs_byteenable == 4'hF) |=> sleep_clock_gate_ctrl_one ==
		($past(avs_writedata) & `SCG_WRITE_MASK))
		else $error("gate write lost");
	a_sleep_follow:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(sleep_s2 && acg_s2) |=> unit_clk_en == $past(sleep_en))
		else $error("sleep enable not applied");
	a_run_follow:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		!(sleep_s2 && acg_s2) |=> unit_clk_en == $past(run_gate_enable))
		else $error("run enable not applied");
	a_fault_gated:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(periph_req.req && periph_req.unit == 4'h0 && !unit_clk_en[0])
		|-> periph_fault)
		else $error("no fault on gated unit");
	a_wait_once:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		(req && avs_waitrequest) |=> (req ##0 !avs_waitrequest))
		else $error("waitrequest not released");
	a_ctrl_bit_map:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		sleep_en[10] == sleep_clock_gate_ctrl_one[26] &&
		sleep_en[3] == sleep_clock_gate_ctrl_one[12])
		else $error("bit map wrong");
	a_irq_sticky:
		assert property (@(posedge ref_clk) disable iff (!arst_n)
		fault_evt |=> irq_stat[0])
		else $error("fault event lost");

endmodule : scg_sleep_gate

// File: tb/scg_sleep_gate_tb.sv
`timescale 1ns/1ps
`include "scg_params.svh"

module scg_sleep_gate_tb;
	logic                      ref_clk, arst_n, avs_read, avs_write;
	logic [11:0]               avs_address;
	logic [31:0]               avs_writedata, avs_readdata, rd;
	logic [3:0]                avs_byteenable;
	logic [1:0]                avs_response, rsp;
	logic                      avs_waitrequest, periph_fault, irq;
	logic                      sleep_active, auto_clock_gating_enable;
	logic [10:0]               run_gate_enable, unit_clk_en, unit_clk;
	scg_pkg::scg_periph_req_s  periph_req;
	int                        num_errors, n_compared;
	// register bit of each unit, in unit order
	int bit_pos[11] = '{0, 1, 4, 12, 16, 17, 18, 19, 24, 25, 26};

	scg_sleep_gate u_scg_sleep_gate (
		.ref_clk                  (ref_clk),
		.arst_n                   (arst_n),
		.avs_address              (avs_address),
		.avs_read                 (avs_read),
		.avs_write                (avs_write),
		.avs_writedata            (avs_writedata),
		.avs_byteenable           (avs_byteenable),
		.avs_readdata             (avs_readdata),
		.avs_response             (avs_response),
		.avs_waitrequest          (avs_waitrequest),
		.sleep_active             (sleep_active),
		.auto_clock_gating_enable (auto_clock_gating_enable),
		.run_gate_enable          (run_gate_enable),
		.periph_req               (periph_req),
		.periph_fault             (periph_fault),
		.unit_clk_en              (unit_clk_en),
		.unit_clk                 (unit_clk),
		.irq                      (irq)
	);

	// free-running 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int n;
		@(posedge ref_clk);
		avs_read <= ~wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) num_errors++;
		rd = avs_readdata;
		rsp = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	// probe one unit for a single cycle, return fault seen
	task automatic probe(input int u, output logic f);
		@(posedge ref_clk);
		periph_req <= {1'b1, 4'(u)};
		@(negedge ref_clk);
		f = periph_fault;
		@(posedge ref_clk);
		periph_req <= '0;
	endtask : probe

	// lets the enable synchroniser settle before looking
	task automatic settle();
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : settle

	task automatic t_reset();
		logic f;
		bus(1'b0, 12'h114, 32'h0, 4'hF);
		chk(rd, `SCG_RESET_VALUE);
		chk(32'(unit_clk_en), 32'h0);
		probe(0, f);
		chk(32'(f), 32'h1);
		$display("test reset done");
	endtask : t_reset

	task automatic t_fields();
		bus(1'b1, 12'h114, 32'hFFFFFFFF, 4'hF);
		bus(1'b0, 12'h114, 32'h0, 4'hF);
		chk(rd, `SCG_WRITE_MASK);
		chk(32'(rsp), 32'h0);
		bus(1'b1, 12'h114, 32'h0, 4'h1);
		bus(1'b0, 12'h114, 32'h0, 4'hF);
		chk(rd, 32'h070F1000);
		$display("test fields done");
	endtask : t_fields

	// each bit alone enables just its unit
	task automatic t_units();
		logic f;
		sleep_active <= 1'b1;
		auto_clock_gating_enable <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			bus(1'b1, 12'h114, 32'h1 << bit_pos[i], 4'hF);
			settle();
			chk(32'(unit_clk_en), 32'h1 << i);
			probe(i, f);
			chk(32'(f), 32'h0);
			probe((i + 1) % 11, f);
			chk(32'(f), 32'h1);
		end
		$display("test units done");
	endtask : t_units

	// sleep gating only when asleep with auto gating on
	task automatic t_modes();
		bus(1'b1, 12'h114, 32'hFFFFFFFF, 4'hF);
		run_gate_enable <= 11'h2A5;
		sleep_active <= 1'b0;
		settle();
		chk(32'(unit_clk_en), 32'h2A5);
		sleep_active <= 1'b1;
		auto_clock_gating_enable <= 1'b0;
		settle();
		chk(32'(unit_clk_en), 32'h2A5);
		@(posedge ref_clk);
		#1;
		chk(32'(unit_clk), 32'h2A5);
		auto_clock_gating_enable <= 1'b1;
		settle();
		chk(32'(unit_clk_en), 32'h7FF);
		@(posedge ref_clk);
		#1;
		chk(32'(unit_clk), 32'h7FF);
		@(negedge ref_clk);
		#1;
		chk(32'(unit_clk), 32'h0);
		$display("test modes done");
	endtask : t_modes

	task automatic t_irq();
		logic f;
		bus(1'b1, 12'h114, 32'h0, 4'hF);
		settle();
		bus(1'b1, 12'h200, 32'h3, 4'hF);
		bus(1'b1, 12'h204, 32'h1, 4'hF);
		@(negedge ref_clk);
		chk(32'(irq), 32'h0);
		probe(3, f);
		settle();
		chk(32'(irq), 32'h1);
		bus(1'b1, 12'h200, 32'h1, 4'hF);
		@(negedge ref_clk);
		chk(32'(irq), 32'h0);
		bus(1'b0, 12'h300, 32'h0, 4'hF);
		chk(32'(rsp), 32'h3);
		@(negedge ref_clk);
		chk(32'(irq), 32'h0);
		bus(1'b1, 12'h204, 32'h2, 4'hF);
		@(negedge ref_clk);
		chk(32'(irq), 32'h1);
		bus(1'b1, 12'h200, 32'h2, 4'hF);
		@(negedge ref_clk);
		chk(32'(irq), 32'h0);
		$display("test irq done");
	endtask : t_irq

	task automatic close_out();
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// watchdog: the tests need well under 2000 cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		num_errors++;
		close_out();
	end

	initial begin
		arst_n = 1'b0;
		{avs_read, avs_write, sleep_active} = '0;
		auto_clock_gating_enable = 1'b0;
		avs_address = '0;
		avs_writedata = '0;
		avs_byteenable = '0;
		run_gate_enable = '0;
		periph_req = '0;
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_reset();
		t_fields();
		t_units();
		t_modes();
		t_irq();
		close_out();
	end
endmodule : scg_sleep_gate_tb
